/* File: dv/gpio_expander_port_hotkey_tb.sv */
// Self-checking bench for the GPIO port block
`timescale 1ns/1ps
module gpio_expander_port_hotkey_tb;
    logic clk, rst_n, alert, wake;
    logic [15:0] pin_in, pin_out, pin_oe_n, pullup_en;
    logic [31:0] func_sel;
    logic [7:0] rdata, other_src_event;
    gpio_expander_pkg::reg_req_t req;
    int err_count = 0;
    int checks_done = 0;
    host_model host (.clk(clk), .req(req));
    gpio_expander_port_hotkey dut (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pullup_en(pullup_en),
        .func_sel(func_sel), .other_src_event(other_src_event), .alert(alert), .wake(wake));
    // 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Compare, counting every check
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Read a register and compare its byte
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a);
        chk({8'h00, rdata}, {8'h00, exp});
    endtask : rchk
    task automatic waitn(input int n);
        repeat (n) @(negedge clk);
    endtask : waitn
    task automatic stop_test;
        $display("checks_done=%0d err_count=%0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    // Outputs, set, clear, pull-ups and function select
    task automatic t_pins;
        host.wr(8'h09, 8'hFF);
        chk(pin_oe_n, 16'hFF00);
        host.wr(8'h08, 8'hFF);
        chk(pin_oe_n, 16'h0000);
        host.wr(8'h03, 8'hA5);
        host.wr(8'h05, 8'h81);
        chk(pin_out, 16'h0024);
        host.wr(8'h02, 8'h01);
        chk(pin_out, 16'h0124);
        host.wr(8'h11, 8'h80);
        chk(pullup_en, 16'h0080);
        host.wr(8'h12, 8'h01);
        host.wr(8'h15, 8'h01);
        chk({14'h0000, func_sel[17:16]}, 16'h0002);
        chk({14'h0000, func_sel[1:0]}, 16'h0001);
        $display("t_pins done");
    endtask : t_pins
    // Live levels; a write to them is ignored
    task automatic t_level;
        pin_in = 16'h3C5A;
        waitn(4);
        rchk(8'h07, 8'h5A);
        host.wr(8'h06, 8'hFF);
        rchk(8'h06, 8'h3C);
        pin_in = 16'h0000;
        waitn(4);
        $display("t_level done");
    endtask : t_level
    // Edge flags, alert modes and the global gate
    task automatic t_edge;
        int hi;
        hi = 0;
        host.wr(8'h15, 8'h00);
        host.wr(8'h09, 8'hFC);
        chk(pin_oe_n, 16'h0003);
        host.wr(8'h0D, 8'h01);
        host.arm(8'h01, 8'h00, 8'h01, 8'h01);
        pin_in[0] = 1'b1;
        waitn(8);
        chk(alert, 1'b1);
        chk(wake, 1'b1);
        rchk(8'h0B, 8'h01);
        rchk(8'h44, 8'h01);
        rchk(8'h49, 8'h01);
        host.wr(8'h0B, 8'h01);
        host.wr(8'h49, 8'h01);
        host.wr(8'h44, 8'h01);
        chk(alert, 1'b0);
        chk(wake, 1'b0);
        pin_in[0] = 1'b0;
        waitn(8);
        rchk(8'h0B, 8'h00);
        host.wr(8'h0D, 8'h00);
        host.wr(8'h0F, 8'h01);
        pin_in[0] = 1'b1;
        waitn(8);
        rchk(8'h0B, 8'h00);
        host.wr(8'h41, 8'h03);
        pin_in[0] = 1'b0;
        repeat (12) begin
            @(negedge clk);
            if (alert === 1'b1) hi++;
        end
        chk(16'(hi), 16'(gpio_expander_pkg::PULSE_CYC));
        chk(alert, 1'b0);
        rchk(8'h0B, 8'h01);
        host.wr(8'h41, 8'h01);
        chk(alert, 1'b1);
        host.wr(8'h41, 8'h00);
        chk(alert, 1'b0);
        rchk(8'h42, 8'h01);
        $display("t_edge done");
    endtask : t_edge
    // Event from another source, cleared by one write
    task automatic t_other;
        host.wr(8'h44, 8'h01);
        host.wr(8'h43, 8'h08);
        host.wr(8'h41, 8'h01);
        other_src_event = 8'h08;
        waitn(1);
        other_src_event = 8'h00;
        waitn(3);
        chk(alert, 1'b1);
        rchk(8'h45, 8'h08);
        host.wr(8'h45, 8'h08);
        chk(alert, 1'b0);
        rchk(8'h45, 8'h00);
        host.wr(8'h49, 8'h01);
        host.wr(8'h0D, 8'h02);
        pin_in[1] = 1'b1;
        waitn(8);
        chk(alert, 1'b0);
        rchk(8'h49, 8'h02);
        rchk(8'h44, 8'h01);
        host.wr(8'h47, 8'h03);
        chk(alert, 1'b1);
        $display("t_other done");
    endtask : t_other
    // Watchdog, far beyond the two hundred or so cycles the tests need
    initial begin
        #2_000_000;
        err_count++;
        stop_test();
    end
    // Reset, then the scenarios
    initial begin
        rst_n = 1'b0;
        pin_in = 16'h0000;
        other_src_event = 8'h00;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        waitn(4);
        t_pins();
        t_level();
        t_edge();
        t_other();
        stop_test();
    end
endmodule : gpio_expander_port_hotkey_tb

/* File: dv/host_model.sv */
// Host model that reaches the port block through its register strobes
`timescale 1ns/1ps
module host_model (
    input wire logic clk,
    output gpio_expander_pkg::reg_req_t req
);
    // Bus idle from time zero
    initial req = '0;
    // One write strobe off the falling edge, effect settled on return
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk);
        req = '0;
        @(negedge clk);
    endtask : wr
    // One read strobe; rdata holds until the next read
    task automatic rd(input logic [7:0] a);
        @(negedge clk);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk);
        req = '0;
        @(negedge clk);
    endtask : rd
    // Masks first, control last, so no alert escapes half set up
    task automatic arm(input logic [7:0] sh, input logic [7:0] sl, input logic [7:0] pl,
        input logic [7:0] ctl);
        wr(8'h42, sh);
        wr(8'h43, sl);
        wr(8'h46, 8'h00);
        wr(8'h47, pl);
        wr(8'h41, ctl);
    endtask : arm
endmodule : host_model

/* File: rtl/gpio_expander_pkg.sv */
// Package with register map, field layouts and timing constants for the GPIO port block
package gpio_expander_pkg;
    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_SET_UPPER = 8'h02;
    localparam logic [7:0] OFS_SET_LOWER = 8'h03;
    localparam logic [7:0] OFS_CLR_UPPER = 8'h04;
    localparam logic [7:0] OFS_CLR_LOWER = 8'h05;
    localparam logic [7:0] OFS_LVL_UPPER = 8'h06;
    localparam logic [7:0] OFS_LVL_LOWER = 8'h07;
    localparam logic [7:0] OFS_DIR_UPPER = 8'h08;
    localparam logic [7:0] OFS_DIR_LOWER = 8'h09;
    localparam logic [7:0] OFS_EDGE_UPPER = 8'h0A;
    localparam logic [7:0] OFS_EDGE_LOWER = 8'h0B;
    localparam logic [7:0] OFS_RISE_UPPER = 8'h0C;
    localparam logic [7:0] OFS_RISE_LOWER = 8'h0D;
    localparam logic [7:0] OFS_FALL_UPPER = 8'h0E;
    localparam logic [7:0] OFS_FALL_LOWER = 8'h0F;
    localparam logic [7:0] OFS_PULL_UPPER = 8'h10;
    localparam logic [7:0] OFS_PULL_LOWER = 8'h11;
    localparam logic [7:0] OFS_FHI_UPPER = 8'h12;
    localparam logic [7:0] OFS_FHI_LOWER = 8'h13;
    localparam logic [7:0] OFS_FLO_UPPER = 8'h14;
    localparam logic [7:0] OFS_FLO_LOWER = 8'h15;
    localparam logic [7:0] OFS_LT_EN = 8'h16;
    localparam logic [7:0] OFS_LT_DIR = 8'h17;
    // Alert controller registers, a separate page of the map
    localparam logic [7:0] OFS_ACTL_UPPER = 8'h40;
    localparam logic [7:0] OFS_ACTL_LOWER = 8'h41;
    localparam logic [7:0] OFS_SMASK_UPPER = 8'h42;
    localparam logic [7:0] OFS_SMASK_LOWER = 8'h43;
    localparam logic [7:0] OFS_SSTAT_UPPER = 8'h44;
    localparam logic [7:0] OFS_SSTAT_LOWER = 8'h45;
    localparam logic [7:0] OFS_PMASK_UPPER = 8'h46;
    localparam logic [7:0] OFS_PMASK_LOWER = 8'h47;
    localparam logic [7:0] OFS_PSTAT_UPPER = 8'h48;
    localparam logic [7:0] OFS_PSTAT_LOWER = 8'h49;
    // ----------------------------------------------------------------
    // Field layout
    // ----------------------------------------------------------------
    localparam int NUM_PINS = 16;
    localparam int NUM_SRC = 9;
    localparam int GATE_BIT = 0;
    localparam int TYPE_BIT = 1;
    localparam int GPIO_SRC_BIT = 8;
    localparam logic [1:0] FUNC_PRIMARY = 2'h0;
    localparam logic [1:0] FUNC_ALT1 = 2'h1;
    localparam logic [1:0] FUNC_ALT2 = 2'h2;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [7:0] READ_ZERO = 8'h00;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int PULSE_NS = 250;
    localparam int PULSE_CYC = (PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int WAKE_MIN_NS = 62_500;
    localparam int WAKE_MIN_CYC = (WAKE_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [3:0] PULSE_LEN = 4'(PULSE_CYC);

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic [15:0] out_level;
        logic [15:0] dir;
        logic [15:0] edge_seen;
        logic [15:0] rise_en;
        logic [15:0] fall_en;
        logic [15:0] pull_en;
        logic [15:0] func_hi;
        logic [15:0] func_lo;
        logic [7:0] lt_en;
        logic [7:0] lt_dir;
        logic [2:0] alert_ctl;
        logic [8:0] src_mask;
        logic [8:0] src_status;
        logic [15:0] pin_mask;
        logic [15:0] pin_status;
    } regs_t;
endpackage : gpio_expander_pkg

/* File: rtl/gpio_expander_port_hotkey.sv */
// GPIO port with edge detection, hot-key alerting and its register file
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
module gpio_expander_port_hotkey (
    input wire logic clk,
    input wire logic rst_n,
    input wire gpio_expander_pkg::reg_req_t req,      // Register access from the serial slave
    output logic [7:0] rdata,                          // Read data, registered
    input wire logic [15:0] pin_in,                    // Pad input levels
    output logic [15:0] pin_out,                       // Pad output levels
    output logic [15:0] pin_oe_n,                      // Pad output enables, low drives
    output logic [15:0] pullup_en,                     // Internal pull-up switches
    output logic [31:0] func_sel,                      // Two bits per pin
    input wire logic [7:0] other_src_event,            // Pulses from non-GPIO sources
    output logic alert,                                // Alert to host, active high
    output logic wake                                  // Wake request to power control
);
    // ----------------------------------------------------------------
    // Reset release and pin synchronisers
    // ----------------------------------------------------------------
    logic [1:0] rst_sync_r;
    logic rst_n_i;
    logic [15:0] pin_meta_r;
    logic [15:0] pin_sync_r;

    // Two-stage reset release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n_i = rst_sync_r[1];

    // Pads are asynchronous to clk; only the second stage is read
    always_ff @(posedge clk or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_meta_r <= 16'h0000;
            pin_sync_r <= 16'h0000;
        end else begin
            pin_meta_r <= pin_in;
            pin_sync_r <= pin_meta_r;
        end
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        gpio_expander_pkg::regs_t regs;
        logic [15:0] pin_prev;     // Last sampled pin level
        logic [3:0] pulse_cnt;     // Edge-mode pulse timer
        logic alert_prev;          // Previous pending condition
        logic [7:0] rdata;         // Read data register
        logic alert;               // Alert output register
    } state_t;

    state_t st_r;
    state_t st_nxt;

    // Byte lane of a pin-group register pair, high byte holds pins 15..8
    function automatic logic [15:0] put_byte(input logic [15:0] w, input logic up,
                                             input logic [7:0] b);
        put_byte = up ? {b, w[7:0]} : {w[15:8], b};
    endfunction : put_byte

    function automatic logic [7:0] get_byte(input logic [15:0] w, input logic up);
        get_byte = up ? w[15:8] : w[7:0];
    endfunction : get_byte

    // Expand a byte write into a 16-bit lane mask
    function automatic logic [15:0] lane(input logic up, input logic [7:0] b);
        lane = up ? {b, 8'h00} : {8'h00, b};
    endfunction : lane

    // Event and decode wires
    logic [15:0] rise_hit;
    logic [15:0] fall_hit;
    logic [15:0] pin_evt;
    logic pending;
    logic pin_pending;
    logic up;

    assign up = (req.addr[0] == 1'b0);

    // Edge detection on synchronised pins; the 20 MHz sampling easily
    // resolves any assertion of 62.5 us, whether sleeping or awake
    assign rise_hit = pin_sync_r & ~st_r.pin_prev & st_r.regs.rise_en;
    assign fall_hit = ~pin_sync_r & st_r.pin_prev & st_r.regs.fall_en;
    assign pin_evt = rise_hit | fall_hit;

    // Pending alert: the GPIO group only counts while an unmasked pin flag stands,
    // though every enabled edge still records its flags; the gate blocks all
    assign pin_pending = |(st_r.regs.pin_status & st_r.regs.pin_mask);
    assign pending = st_r.regs.alert_ctl[gpio_expander_pkg::GATE_BIT] &
                     ((|(st_r.regs.src_status[7:0] & st_r.regs.src_mask[7:0])) |
                      (st_r.regs.src_status[gpio_expander_pkg::GPIO_SRC_BIT] &
                       st_r.regs.src_mask[gpio_expander_pkg::GPIO_SRC_BIT] & pin_pending));

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        logic [15:0] wmask;
        wmask = 16'h0000;
        st_nxt = st_r;
        st_nxt.pin_prev = pin_sync_r;
        st_nxt.rdata = st_r.rdata;
        wmask = lane(up, req.wdata);

        // Register writes
        if (req.wr) begin
            case (req.addr)
                gpio_expander_pkg::OFS_SET_UPPER, gpio_expander_pkg::OFS_SET_LOWER: begin
                    st_nxt.regs.out_level = st_r.regs.out_level | wmask;
                end
                gpio_expander_pkg::OFS_CLR_UPPER, gpio_expander_pkg::OFS_CLR_LOWER: begin
                    st_nxt.regs.out_level = st_r.regs.out_level & ~wmask;
                end
                gpio_expander_pkg::OFS_DIR_UPPER, gpio_expander_pkg::OFS_DIR_LOWER: begin
                    st_nxt.regs.dir = put_byte(st_r.regs.dir, up, req.wdata);
                end
                gpio_expander_pkg::OFS_EDGE_UPPER, gpio_expander_pkg::OFS_EDGE_LOWER: begin
                    st_nxt.regs.edge_seen = st_r.regs.edge_seen & ~wmask;
                end
                gpio_expander_pkg::OFS_RISE_UPPER, gpio_expander_pkg::OFS_RISE_LOWER: begin
                    st_nxt.regs.rise_en = put_byte(st_r.regs.rise_en, up, req.wdata);
                end
                gpio_expander_pkg::OFS_FALL_UPPER, gpio_expander_pkg::OFS_FALL_LOWER: begin
                    st_nxt.regs.fall_en = put_byte(st_r.regs.fall_en, up, req.wdata);
                end
                gpio_expander_pkg::OFS_PULL_UPPER, gpio_expander_pkg::OFS_PULL_LOWER: begin
                    st_nxt.regs.pull_en = put_byte(st_r.regs.pull_en, up, req.wdata);
                end
                gpio_expander_pkg::OFS_FHI_UPPER, gpio_expander_pkg::OFS_FHI_LOWER: begin
                    st_nxt.regs.func_hi = put_byte(st_r.regs.func_hi, up, req.wdata);
                end
                gpio_expander_pkg::OFS_FLO_UPPER, gpio_expander_pkg::OFS_FLO_LOWER: begin
                    st_nxt.regs.func_lo = put_byte(st_r.regs.func_lo, up, req.wdata);
                end
                gpio_expander_pkg::OFS_LT_EN: begin
                    st_nxt.regs.lt_en = req.wdata;
                end
                gpio_expander_pkg::OFS_LT_DIR: begin
                    st_nxt.regs.lt_dir = req.wdata;
                end
                gpio_expander_pkg::OFS_ACTL_LOWER: begin
                    // Gate, type and spare bit 2 only; the source mask is untouched
                    st_nxt.regs.alert_ctl = req.wdata[2:0];
                end
                gpio_expander_pkg::OFS_SMASK_UPPER: begin
                    st_nxt.regs.src_mask[8] = req.wdata[0];
                end
                gpio_expander_pkg::OFS_SMASK_LOWER: begin
                    st_nxt.regs.src_mask[7:0] = req.wdata;
                end
                gpio_expander_pkg::OFS_SSTAT_UPPER: begin
                    if (req.wdata[0]) begin
                        st_nxt.regs.src_status[8] = 1'b0;
                    end
                end
                gpio_expander_pkg::OFS_SSTAT_LOWER: begin
                    st_nxt.regs.src_status[7:0] = st_r.regs.src_status[7:0] & ~req.wdata;
                end
                gpio_expander_pkg::OFS_PMASK_UPPER, gpio_expander_pkg::OFS_PMASK_LOWER: begin
                    st_nxt.regs.pin_mask = put_byte(st_r.regs.pin_mask, ~req.addr[0],
                                                    req.wdata);
                end
                gpio_expander_pkg::OFS_PSTAT_UPPER, gpio_expander_pkg::OFS_PSTAT_LOWER: begin
                    st_nxt.regs.pin_status = st_r.regs.pin_status &
                                             ~lane(~req.addr[0], req.wdata);
                end
                default: begin
                    // Unmapped and level registers ignore writes
                end
            endcase
        end

        // Hardware sets win over same-cycle clears
        st_nxt.regs.edge_seen = st_nxt.regs.edge_seen | pin_evt;
        st_nxt.regs.pin_status = st_nxt.regs.pin_status | pin_evt;
        // Group flag follows any pin event; the pin mask acts only on the alert path
        if (|pin_evt) begin
            st_nxt.regs.src_status[gpio_expander_pkg::GPIO_SRC_BIT] = 1'b1;
        end
        st_nxt.regs.src_status[7:0] = st_nxt.regs.src_status[7:0] | other_src_event;

        // Register reads, data registered one cycle after the strobe
        if (req.rd) begin
            case (req.addr)
                gpio_expander_pkg::OFS_LVL_UPPER, gpio_expander_pkg::OFS_LVL_LOWER: begin
                    st_nxt.rdata = get_byte(pin_sync_r, up);
                end
                gpio_expander_pkg::OFS_DIR_UPPER, gpio_expander_pkg::OFS_DIR_LOWER: begin
                    st_nxt.rdata = get_byte(st_r.regs.dir, up);
                end
                gpio_expander_pkg::OFS_EDGE_UPPER, gpio_expander_pkg::OFS_EDGE_LOWER: begin
                    st_nxt.rdata = get_byte(st_r.regs.edge_seen, up);
                end
                gpio_expander_pkg::OFS_RISE_UPPER, gpio_expander_pkg::OFS_RISE_LOWER: begin
                    st_nxt.rdata = get_byte(st_r.regs.rise_en, up);
                end
                gpio_expander_pkg::OFS_FALL_UPPER, gpio_expander_pkg::OFS_FALL_LOWER: begin
                    st_nxt.rdata = get_byte(st_r.regs.fall_en, up);
                end
                gpio_expander_pkg::OFS_PULL_UPPER, gpio_expander_pkg::OFS_PULL_LOWER: begin
                    st_nxt.rdata = get_byte(st_r.regs.pull_en, up);
                end
                gpio_expander_pkg::OFS_FHI_UPPER, gpio_expander_pkg::OFS_FHI_LOWER: begin
                    st_nxt.rdata = get_byte(st_r.regs.func_hi, up);
                end
                gpio_expander_pkg::OFS_FLO_UPPER, gpio_expander_pkg::OFS_FLO_LOWER: begin
                    st_nxt.rdata = get_byte(st_r.regs.func_lo, up);
                end
                gpio_expander_pkg::OFS_LT_EN: begin
                    st_nxt.rdata = st_r.regs.lt_en;
                end
                gpio_expander_pkg::OFS_LT_DIR: begin
                    st_nxt.rdata = st_r.regs.lt_dir;
                end
                gpio_expander_pkg::OFS_ACTL_LOWER: begin
                    st_nxt.rdata = {5'h00, st_r.regs.alert_ctl};
                end
                gpio_expander_pkg::OFS_SMASK_UPPER: begin
                    st_nxt.rdata = {7'h00, st_r.regs.src_mask[8]};
                end
                gpio_expander_pkg::OFS_SMASK_LOWER: begin
                    st_nxt.rdata = st_r.regs.src_mask[7:0];
                end
                gpio_expander_pkg::OFS_SSTAT_UPPER: begin
                    st_nxt.rdata = {7'h00, st_r.regs.src_status[8]};
                end
                gpio_expander_pkg::OFS_SSTAT_LOWER: begin
                    st_nxt.rdata = st_r.regs.src_status[7:0];
                end
                gpio_expander_pkg::OFS_PMASK_UPPER, gpio_expander_pkg::OFS_PMASK_LOWER: begin
                    st_nxt.rdata = get_byte(st_r.regs.pin_mask, ~req.addr[0]);
                end
                gpio_expander_pkg::OFS_PSTAT_UPPER, gpio_expander_pkg::OFS_PSTAT_LOWER: begin
                    st_nxt.rdata = get_byte(st_r.regs.pin_status, ~req.addr[0]);
                end
                default: begin
                    // Write-only, reserved and unmapped read as zero
                    st_nxt.rdata = gpio_expander_pkg::READ_ZERO;
                end
            endcase
        end

        // Alert generation: level follows pending, edge gives one timed pulse
        st_nxt.alert_prev = pending;
        if (st_r.regs.alert_ctl[gpio_expander_pkg::TYPE_BIT]) begin
            if (pending && !st_r.alert_prev) begin
                st_nxt.pulse_cnt = gpio_expander_pkg::PULSE_LEN;
            end else if (st_r.pulse_cnt != 4'h0) begin
                st_nxt.pulse_cnt = st_r.pulse_cnt - 4'h1;
            end
            st_nxt.alert = (st_nxt.pulse_cnt != 4'h0);
        end else begin
            st_nxt.pulse_cnt = 4'h0;
            st_nxt.alert = pending;
        end
        if (!st_r.regs.alert_ctl[gpio_expander_pkg::GATE_BIT]) begin
            st_nxt.alert = 1'b0;
            st_nxt.pulse_cnt = 4'h0;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign rdata = st_r.rdata;
    assign alert = st_r.alert;
    assign wake = st_r.alert_prev;
    assign pin_out = st_r.regs.out_level;
    assign pin_oe_n = ~st_r.regs.dir;
    assign pullup_en = st_r.regs.pull_en;

    // Per-pin two-bit select, upper register gives the high bit
    genvar gi;
    generate
        for (gi = 0; gi < gpio_expander_pkg::NUM_PINS; gi++) begin : g_func
            assign func_sel[2*gi +: 2] = {st_r.regs.func_hi[gi], st_r.regs.func_lo[gi]};
        end
    endgenerate

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_gate_blocks: assert property (@(posedge clk) disable iff (!rst_n_i)
        !st_r.regs.alert_ctl[gpio_expander_pkg::GATE_BIT] |=> !alert)
        else $error("alert seen with gate closed");
    a_level_follows: assert property (@(posedge clk) disable iff (!rst_n_i)
        (!st_r.regs.alert_ctl[gpio_expander_pkg::TYPE_BIT] &&
         st_r.regs.alert_ctl[gpio_expander_pkg::GATE_BIT]) |=> (alert == $past(pending)))
        else $error("level alert does not follow pending");
    // Full pulse is five cycles of 50 ns; a write in the window may close the gate
    a_edge_pulse_len: assert property (@(posedge clk) disable iff (!rst_n_i)
        ($rose(alert) && st_r.regs.alert_ctl[gpio_expander_pkg::TYPE_BIT] && !req.wr) |->
        alert [*5])
        else $error("edge alert pulse too short");
    a_edge_sets_flag: assert property (@(posedge clk) disable iff (!rst_n_i)
        (|pin_evt) |=> ((st_r.regs.edge_seen & $past(pin_evt)) == $past(pin_evt)))
        else $error("edge flag not set");
    a_group_flag: assert property (@(posedge clk) disable iff (!rst_n_i)
        (|pin_evt) |=> st_r.regs.src_status[gpio_expander_pkg::GPIO_SRC_BIT])
        else $error("group flag not set");
    a_set_drives: assert property (@(posedge clk) disable iff (!rst_n_i)
        (req.wr && req.addr == gpio_expander_pkg::OFS_SET_LOWER) |=>
        ((pin_out[7:0] & $past(req.wdata)) == $past(req.wdata)))
        else $error("set write did not drive high");
    a_clr_drives: assert property (@(posedge clk) disable iff (!rst_n_i)
        (req.wr && req.addr == gpio_expander_pkg::OFS_CLR_LOWER) |=>
        ((pin_out[7:0] & $past(req.wdata)) == 8'h00))
        else $error("clear write did not drive low");
    a_dir_oe: assert property (@(posedge clk) disable iff (!rst_n_i)
        (req.wr && req.addr == gpio_expander_pkg::OFS_DIR_LOWER) |=>
        (pin_oe_n[7:0] == ~$past(req.wdata)))
        else $error("output enable mismatches direction write");
    a_rise_masked: assert property (@(posedge clk) disable iff (!rst_n_i)
        (st_r.regs.rise_en == 16'h0000 && st_r.regs.fall_en == 16'h0000) |-> !(|pin_evt))
        else $error("event with detection off");
    // Level mode with no unmasked source standing must leave the alert low
    a_pin_mask_gate: assert property (@(posedge clk) disable iff (!rst_n_i)
        (!st_r.regs.alert_ctl[gpio_expander_pkg::TYPE_BIT] &&
         !(|(st_r.regs.pin_status & st_r.regs.pin_mask)) &&
         !(|(st_r.regs.src_status[7:0] & st_r.regs.src_mask[7:0]))) |=> !alert)
        else $error("alert without an unmasked source");
    a_pin_flag_clear: assert property (@(posedge clk) disable iff (!rst_n_i)
        (req.wr && req.addr == gpio_expander_pkg::OFS_PSTAT_LOWER) |=>
        ((st_r.regs.pin_status[7:0] & $past(req.wdata) & ~$past(pin_evt[7:0])) == 8'h00))
        else $error("pin flag not cleared by write");
    a_src_flag_clear: assert property (@(posedge clk) disable iff (!rst_n_i)
        (req.wr && req.addr == gpio_expander_pkg::OFS_SSTAT_LOWER) |=>
        ((st_r.regs.src_status[7:0] & $past(req.wdata) & ~$past(other_src_event)) == 8'h00))
        else $error("source flag not cleared by write");
    a_edge_flag_clear: assert property (@(posedge clk) disable iff (!rst_n_i)
        (req.wr && req.addr == gpio_expander_pkg::OFS_EDGE_LOWER) |=>
        ((st_r.regs.edge_seen[7:0] & $past(req.wdata) & ~$past(pin_evt[7:0])) == 8'h00))
        else $error("edge flag not cleared by write");
    a_level_live: assert property (@(posedge clk) disable iff (!rst_n_i)
        (req.rd && req.addr == gpio_expander_pkg::OFS_LVL_LOWER) |=>
        (rdata == $past(pin_sync_r[7:0])))
        else $error("level read not the live pins");
endmodule : gpio_expander_port_hotkey
